// [shared/flash_seq_pkg.sv]
// command codes, field positions and timing constants for the erase/suspend sequencer
// assumes a 125 MHz system clock and a serial link already sampled into that domain
package flash_seq_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_BLOCK_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

  // ---------------------------------------------------------------
  // framing and address layout
  // ---------------------------------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam int ADDR_W = 32;
  localparam logic [2:0] ADDR_CMD_BYTES = 3'h5;
  localparam int SECTOR_LSB = 18;
  localparam logic [7:0] UNDEF_READ_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SUSPEND_LATENCY_NS = 1000;
  localparam int SUSPEND_LATENCY_CYC = (SUSPEND_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                       (SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
  localparam int SUSP_CNT_W = $clog2(SUSPEND_LATENCY_CYC + 1);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_BUSY = 2'b01,
    PH_SUSP_WAIT = 2'b10
  } phase_t;

  typedef enum logic [1:0] {
    OPK_NONE = 2'b00,
    OPK_CHIP_ERASE = 2'b01,
    OPK_BLOCK_ERASE = 2'b10,
    OPK_PROGRAM = 2'b11
  } op_kind_t;

  // reset values
  localparam logic WEL_RESET = 1'b0;

endpackage

// [hdl/frame_deframer.sv]
// serial command framer: counts bits and bytes of one chip-select frame
// assumes bit strobes and chip select already synchronous to clk_sys_i
`timescale 1ns/1ns
module frame_deframer
  import flash_seq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic bit_strobe_i,
  input wire logic bit_i,
  output logic frame_end_o,
  output logic whole_bytes_o,
  output logic [2:0] byte_count_o,
  output logic [7:0] opcode_o,
  output logic [ADDR_W-1:0] addr_o
);

  typedef struct packed {
    logic cs_n_q;
    logic frame_end;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
  } defr_state_t;

  defr_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    state_next.cs_n_q = cs_n_i;
    state_next.frame_end = cs_n_i && !state_reg.cs_n_q;
    // new frame: counts restart on the falling edge of chip select
    if (!cs_n_i && state_reg.cs_n_q) begin
      state_next.bit_cnt = 3'h0;
      state_next.byte_cnt = 3'h0;
    end
    if (!cs_n_i && bit_strobe_i) begin
      state_next.shift = {state_reg.shift[6:0], bit_i};
      state_next.bit_cnt = (!cs_n_i && state_reg.cs_n_q) ? 3'h1 : state_reg.bit_cnt + 3'h1;
      if (state_next.bit_cnt == 3'h0) begin
        // saturate so trailing data bytes never wrap the count
        if (state_reg.byte_cnt != 3'h7) begin
          state_next.byte_cnt = state_reg.byte_cnt + 3'h1;
        end
        if (state_reg.byte_cnt == 3'h0) begin
          state_next.opcode = {state_reg.shift[6:0], bit_i};
        end else if (state_reg.byte_cnt < ADDR_CMD_BYTES) begin
          state_next.addr = {state_reg.addr[ADDR_W-9:0], state_reg.shift[6:0], bit_i};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= '{cs_n_q: 1'b1, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign frame_end_o = state_reg.frame_end;
  assign whole_bytes_o = (state_reg.bit_cnt == 3'h0);
  assign byte_count_o = state_reg.byte_cnt;
  assign opcode_o = state_reg.opcode;
  assign addr_o = state_reg.addr;

endmodule // frame_deframer

// [hdl/flash_erase_suspend_seq.sv]
// erase / program / suspend command sequencer of the serial flash
// assumes an array engine that runs one operation per start pulse, pauses on hold and reports done and fail
// Contract
// (RULE1) whole-array erase only starts with write enable latch set; host writes enable first
// (RULE2) opcodes 60h and C7h both start the identical whole-array erase
// (RULE3) whole-array erase takes no address, ignores trailing bytes, starts on chip select rise
// (RULE4) opcode must be complete and chip select raised on byte boundary, else no erase
// (RULE5) any protected sector refuses whole-array erase; device returns idle
// (RULE6) mid-byte chip select rise or protection refusal clears write enable latch
// (RULE7) busy is reported while whole-array erase runs; host polls status
// (RULE8) successful erase clears write enable latch before it finishes
// (RULE9) a byte failing to erase sets the erase/program error flag
// (RULE10) after block erase suspend a program may run in another sector, then resume
// (RULE11) only block erase suspends; suspend during whole-array erase is ignored
// (RULE12) suspend is accepted whatever the write enable latch holds
// (RULE13) suspend takes no address, ignores trailing bytes, suspends within latency after chip select
// (RULE14) suspension sets program or erase suspended flag and shows device ready
// (RULE15) incomplete suspend opcode or mid-byte chip select rise performs no suspend
// (RULE16) reads in a suspended sector return undefined data while address stays there
// (RULE17) program aimed at erase-suspended sector aborts and clears write enable latch
// (RULE18) program run during erase suspend may suspend; both flags then set
// (RULE19) no new erase starts while an erase is suspended
// (RULE20) program or erase attempts during program suspend are aborted
// (RULE21) disallowed commands during suspend are ignored, write enable latch unchanged
// (RULE22) suspend is unavailable when either automatic power-down bit is set
// (RULE23) suspend accepted during running operation; during erase suspend only for its program
// (RULE24) suspend with nothing running changes no flag and no array content
`timescale 1ns/1ns
module flash_erase_suspend_seq
  import flash_seq_pkg::*;
#(
  parameter int SECTOR_W = 5
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic bit_strobe_i,
  input wire logic bit_i,
  input wire logic any_sector_protected_i,
  input wire logic addr_protected_i,
  input wire logic auto_deep_powerdown_bit_i,
  input wire logic auto_ultra_deep_powerdown_bit_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic read_active_i,
  input wire logic [ADDR_W-1:0] read_addr_i,
  input wire logic [7:0] array_data_i,
  output logic write_enable_latch_o,
  output logic erase_program_error_flag_o,
  output logic program_suspended_flag_o,
  output logic erase_suspended_flag_o,
  output logic device_idle_flag_o,
  output logic op_start_o,
  output logic [1:0] op_kind_o,
  output logic [ADDR_W-1:0] op_addr_o,
  output logic erase_hold_o,
  output logic program_hold_o,
  output logic [ADDR_W-1:0] target_addr_o,
  output logic read_undef_o,
  output logic [7:0] read_data_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SECTOR_W < 1 || SECTOR_LSB + SECTOR_W > ADDR_W) begin : g_bad_sector
    $error("SECTOR_W does not fit in the address");
  end
  if (SUSPEND_LATENCY_CYC < 3) begin : g_bad_latency
    $error("suspend latency too short for the pipeline");
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic logic is_chip_erase(input logic [7:0] op);
    return (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B); // see (RULE2)
  endfunction

  function automatic logic is_block_erase(input logic [7:0] op);
    return (op == OP_BLOCK_ERASE_4K) || (op == OP_BLOCK_ERASE_32K) || (op == OP_BLOCK_ERASE_64K);
  endfunction

  function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    return a[SECTOR_LSB +: SECTOR_W];
  endfunction

  // ---------------------------------------------------------------
  // framer
  // ---------------------------------------------------------------
  logic frame_end;
  logic whole_bytes;
  logic [2:0] byte_count;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] frame_addr;

  frame_deframer u_deframer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n_i),
    .bit_strobe_i(bit_strobe_i),
    .bit_i(bit_i),
    .frame_end_o(frame_end),
    .whole_bytes_o(whole_bytes),
    .byte_count_o(byte_count),
    .opcode_o(opcode),
    .addr_o(frame_addr)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic idle;
    op_kind_t run_kind;
    logic [SUSP_CNT_W-1:0] susp_cnt;
    logic write_enable_latch;
    logic erase_program_error_flag;
    logic prog_susp;
    logic erase_susp;
    logic [SECTOR_W-1:0] erase_sector;
    logic [SECTOR_W-1:0] prog_sector;
    logic op_start;
    logic [ADDR_W-1:0] op_addr;
    logic [ADDR_W-1:0] target_addr;
    logic read_undef;
    logic [7:0] read_data;
  } seq_state_t;

  seq_state_t state_reg, state_next;

  logic has_opcode;
  logic complete_addr;
  logic busy;
  logic suspended;
  logic power_down_armed;
  logic read_hit;

  always_comb begin
    has_opcode = (byte_count != 3'h0);
    complete_addr = (byte_count >= ADDR_CMD_BYTES);
    busy = (state_reg.phase != PH_IDLE);
    suspended = state_reg.prog_susp || state_reg.erase_susp;
    power_down_armed = auto_deep_powerdown_bit_i || auto_ultra_deep_powerdown_bit_i;
    read_hit = (state_reg.erase_susp && sector_of(read_addr_i) == state_reg.erase_sector) ||
               (state_reg.prog_susp && sector_of(read_addr_i) == state_reg.prog_sector);

    state_next = state_reg;
    state_next.op_start = 1'b0;
    state_next.target_addr = frame_addr;

    // reads: each byte re-checked, so a sequential read leaves undefined data once past the sector
    state_next.read_undef = read_active_i && read_hit; // see (RULE16)
    state_next.read_data = (read_active_i && read_hit) ? UNDEF_READ_BYTE : array_data_i; // see (RULE16)

    // ---------------------------------------------------------------
    // running operation
    // ---------------------------------------------------------------
    if (state_reg.phase != PH_IDLE && op_fail_i) begin
      state_next.erase_program_error_flag = 1'b1; // see (RULE9)
    end
    case (state_reg.phase)
      PH_BUSY: begin
        if (op_done_i) begin
          state_next.phase = PH_IDLE;
          state_next.run_kind = OPK_NONE;
        end
      end
      PH_SUSP_WAIT: begin
        if (op_done_i) begin
          // finished before the pause landed: nothing is left to suspend
          state_next.phase = PH_IDLE;
          state_next.run_kind = OPK_NONE;
        end else if (state_reg.susp_cnt == SUSP_CNT_W'(1)) begin
          state_next.phase = PH_IDLE; // see (RULE14)
          if (state_reg.run_kind == OPK_PROGRAM) begin
            state_next.prog_susp = 1'b1; // see (RULE18)
          end else begin
            state_next.erase_susp = 1'b1; // see (RULE14)
          end
          state_next.run_kind = OPK_NONE;
        end else begin
          state_next.susp_cnt = state_reg.susp_cnt - SUSP_CNT_W'(1);
        end
      end
      PH_IDLE: begin
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase

    // ---------------------------------------------------------------
    // command at the end of a frame
    // ---------------------------------------------------------------
    if (frame_end && has_opcode) begin
      if (is_chip_erase(opcode)) begin
        // not allowed while busy or suspended: ignored, latch untouched
        if (!busy && !suspended && state_reg.write_enable_latch) begin // see (RULE1) (RULE19) (RULE20) (RULE21)
          if (!whole_bytes || any_sector_protected_i) begin
            state_next.write_enable_latch = 1'b0; // see (RULE4) (RULE5) (RULE6)
          end else begin
            state_next.phase = PH_BUSY; // see (RULE3) (RULE7)
            state_next.run_kind = OPK_CHIP_ERASE;
            state_next.op_start = 1'b1;
            state_next.op_addr = '0;
            state_next.write_enable_latch = 1'b0; // see (RULE8)
            state_next.erase_program_error_flag = 1'b0;
          end
        end
      end else if (is_block_erase(opcode)) begin
        if (!busy && !suspended && state_reg.write_enable_latch) begin // see (RULE19) (RULE20) (RULE21)
          if (!whole_bytes || !complete_addr || addr_protected_i) begin
            state_next.write_enable_latch = 1'b0;
          end else begin
            state_next.phase = PH_BUSY;
            state_next.run_kind = OPK_BLOCK_ERASE;
            state_next.op_start = 1'b1;
            state_next.op_addr = frame_addr;
            state_next.erase_sector = sector_of(frame_addr);
            state_next.write_enable_latch = 1'b0; // see (RULE8)
            state_next.erase_program_error_flag = 1'b0;
          end
        end
      end else if (opcode == OP_PAGE_PROGRAM) begin
        if (!busy && !state_reg.prog_susp && state_reg.write_enable_latch) begin // see (RULE20)
          if (state_reg.erase_susp && sector_of(frame_addr) == state_reg.erase_sector) begin
            state_next.write_enable_latch = 1'b0; // see (RULE17)
          end else if (!whole_bytes || !complete_addr || addr_protected_i) begin
            state_next.write_enable_latch = 1'b0;
          end else begin
            state_next.phase = PH_BUSY; // see (RULE10)
            state_next.run_kind = OPK_PROGRAM;
            state_next.op_start = 1'b1;
            state_next.op_addr = frame_addr;
            state_next.prog_sector = sector_of(frame_addr);
            state_next.write_enable_latch = 1'b0;
            state_next.erase_program_error_flag = 1'b0;
          end
        end
      end else if (opcode == OP_SUSPEND) begin
        // latch is not consulted; a second suspend during an open wait is a no-op
        if (whole_bytes && !power_down_armed && state_reg.phase == PH_BUSY && // see (RULE12) (RULE13) (RULE15) (RULE22)
            (state_reg.run_kind == OPK_BLOCK_ERASE || state_reg.run_kind == OPK_PROGRAM)) begin // see (RULE11) (RULE23) (RULE24)
          state_next.phase = PH_SUSP_WAIT;
          // two cycles of the latency go to seeing chip select and decoding
          state_next.susp_cnt = SUSP_CNT_W'(SUSPEND_LATENCY_CYC - 2);
        end
      end else if (opcode == OP_RESUME) begin
        // the innermost suspension resumes first
        if (whole_bytes && !busy) begin // see (RULE10)
          if (state_reg.prog_susp) begin
            state_next.prog_susp = 1'b0;
            state_next.phase = PH_BUSY;
            state_next.run_kind = OPK_PROGRAM;
          end else if (state_reg.erase_susp) begin
            state_next.erase_susp = 1'b0;
            state_next.phase = PH_BUSY;
            state_next.run_kind = OPK_BLOCK_ERASE;
          end
        end
      end else if (opcode == OP_WRITE_ENABLE) begin
        if (whole_bytes && !busy) begin
          state_next.write_enable_latch = 1'b1;
        end
      end else if (opcode == OP_WRITE_DISABLE) begin
        if (whole_bytes && !busy) begin
          state_next.write_enable_latch = 1'b0;
        end
      end
      // any other opcode is outside this block and leaves every flag alone, see (RULE21)
    end
    state_next.idle = (state_next.phase == PH_IDLE); // see (RULE7) (RULE14)
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= '{phase: PH_IDLE, idle: 1'b1, run_kind: OPK_NONE, write_enable_latch: WEL_RESET, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign write_enable_latch_o = state_reg.write_enable_latch;
  assign erase_program_error_flag_o = state_reg.erase_program_error_flag;
  assign program_suspended_flag_o = state_reg.prog_susp;
  assign erase_suspended_flag_o = state_reg.erase_susp;
  assign device_idle_flag_o = state_reg.idle; // see (RULE7) (RULE14)
  assign op_start_o = state_reg.op_start;
  assign op_kind_o = state_reg.run_kind;
  assign op_addr_o = state_reg.op_addr;
  assign erase_hold_o = state_reg.erase_susp;
  assign program_hold_o = state_reg.prog_susp;
  assign target_addr_o = state_reg.target_addr;
  assign read_undef_o = state_reg.read_undef;
  assign read_data_o = state_reg.read_data;

endmodule // flash_erase_suspend_seq

// [dv/flash_seq_checker.sv]
// concurrent checks on the erase/suspend sequencer ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module flash_seq_checker
  import flash_seq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic auto_deep_powerdown_bit_i,
  input wire logic auto_ultra_deep_powerdown_bit_i,
  input wire logic op_fail_i,
  input wire logic write_enable_latch_o,
  input wire logic erase_program_error_flag_o,
  input wire logic program_suspended_flag_o,
  input wire logic erase_suspended_flag_o,
  input wire logic device_idle_flag_o,
  input wire logic op_start_o,
  input wire logic [1:0] op_kind_o,
  input wire logic [ADDR_W-1:0] op_addr_o,
  input wire logic read_undef_o,
  input wire logic [7:0] read_data_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_start_latch: assert property (op_start_o |-> $past(write_enable_latch_o))
    else $error("operation started without the latch");
  chk_start_clear: assert property (op_start_o |-> !write_enable_latch_o && !device_idle_flag_o)
    else $error("start did not clear latch or show busy");
  chk_start_frame: assert property (op_start_o |-> $past(cs_n_i) && $past(cs_n_i, 2))
    else $error("operation started inside a frame");
  chk_chip_addr: assert property (op_start_o && op_kind_o == OPK_CHIP_ERASE |-> op_addr_o == '0)
    else $error("whole-array erase carries an address");
  chk_fail_flag: assert property (op_fail_i && !device_idle_flag_o |=> erase_program_error_flag_o)
    else $error("failure not flagged");
  chk_chip_nosusp: assert property (op_kind_o == OPK_CHIP_ERASE |->
    !erase_suspended_flag_o && !program_suspended_flag_o)
    else $error("whole-array erase suspended");
  chk_susp_ready: assert property ($rose(erase_suspended_flag_o) || $rose(program_suspended_flag_o) |->
    device_idle_flag_o && !$past(device_idle_flag_o))
    else $error("suspend flag without ready change");
  chk_susp_power: assert property ($rose(erase_suspended_flag_o) || $rose(program_suspended_flag_o) |->
    !auto_deep_powerdown_bit_i && !auto_ultra_deep_powerdown_bit_i)
    else $error("suspend taken with a power-down bit set");
  chk_undef_read: assert property (read_undef_o |-> read_data_o == UNDEF_READ_BYTE &&
    ($past(erase_suspended_flag_o) || $past(program_suspended_flag_o)))
    else $error("undefined read outside suspension");
endmodule // flash_seq_checker

bind flash_erase_suspend_seq flash_seq_checker u_checker (
  .clk_sys_i, .rst_i, .cs_n_i, .auto_deep_powerdown_bit_i, .auto_ultra_deep_powerdown_bit_i,
  .op_fail_i, .write_enable_latch_o, .erase_program_error_flag_o, .program_suspended_flag_o,
  .erase_suspended_flag_o, .device_idle_flag_o, .op_start_o, .op_kind_o, .op_addr_o,
  .read_undef_o, .read_data_o
);

// [dv/array_engine_model.sv]
// array engine stand-in: runs each started operation for a fixed time
// assumes hold levels pause the running kind; a reload drops the paused job
`timescale 1ns/1ns
module array_engine_model
  import flash_seq_pkg::*;
#(
  parameter int DUR = 600
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [1:0] kind_i,
  input wire logic erase_hold_i,
  input wire logic program_hold_i,
  output logic done_o
);
  int cnt;
  logic held;

  assign held = (kind_i == OPK_PROGRAM) ? program_hold_i : erase_hold_i;

  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cnt <= 0;
    end else if (start_i) begin
      cnt <= DUR;
    end else if (cnt > 0 && !held) begin
      cnt <= cnt - 1;
      done_o <= (cnt == 1);
    end
  end
endmodule // array_engine_model

// [dv/tb_top.sv]
// self-checking bench for the erase/suspend sequencer
// assumes the engine model answers every started operation
`timescale 1ns/1ns
module tb_top;
  import flash_seq_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n_i = 1'b1;
  logic bit_strobe_i = 1'b0;
  logic bit_i = 1'b0;
  logic any_sector_protected_i = 1'b0;
  logic addr_protected_i = 1'b0;
  logic auto_deep_powerdown_bit_i = 1'b0;
  logic auto_ultra_deep_powerdown_bit_i = 1'b0;
  logic op_fail_i = 1'b0;
  logic read_active_i = 1'b0;
  logic [ADDR_W-1:0] read_addr_i = '0;
  logic [7:0] array_data_i = 8'h00;
  logic op_done_i, write_enable_latch_o, erase_program_error_flag_o, program_suspended_flag_o;
  logic erase_suspended_flag_o, device_idle_flag_o, op_start_o, erase_hold_o, program_hold_o;
  logic read_undef_o;
  logic [1:0] op_kind_o;
  logic [ADDR_W-1:0] op_addr_o, target_addr_o;
  logic [7:0] read_data_o;
  logic [7:0] op;
  int seed = 40;
  int err_count = 0;
  int checks_done = 0;
  logic [4:0] st_q[$];
  logic [8:0] rd_q[$];
  logic [33:0] kind_q[$];
  event st_ev;
  event rd_ev;

  always #4 clk_sys_i = ~clk_sys_i;

  flash_erase_suspend_seq dut (
    .clk_sys_i, .rst_i, .cs_n_i, .bit_strobe_i, .bit_i, .any_sector_protected_i, .addr_protected_i,
    .auto_deep_powerdown_bit_i, .auto_ultra_deep_powerdown_bit_i, .op_done_i, .op_fail_i,
    .read_active_i, .read_addr_i, .array_data_i, .write_enable_latch_o, .erase_program_error_flag_o,
    .program_suspended_flag_o, .erase_suspended_flag_o, .device_idle_flag_o, .op_start_o,
    .op_kind_o, .op_addr_o, .erase_hold_o, .program_hold_o, .target_addr_o, .read_undef_o,
    .read_data_o
  );
  array_engine_model engine (
    .clk_sys_i, .rst_i, .start_i(op_start_o), .kind_i(op_kind_o), .erase_hold_i(erase_hold_o),
    .program_hold_i(program_hold_o), .done_o(op_done_i)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
  endtask
  task automatic bitout(input logic v);
    bit_strobe_i = 1'b1;
    bit_i = v;
    @(negedge clk_sys_i);
  endtask
  // whole bytes first, then tail random bits to end off a byte boundary
  task automatic frame(input logic [7:0] b[$], input int tail);
    @(negedge clk_sys_i);
    cs_n_i = 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) bitout(b[i][k]);
    end
    for (int k = 0; k < tail; k++) bitout(rnd() > 8'h7F);
    cs_n_i = 1'b1;
    bit_strobe_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic expect_st(input logic [4:0] v);
    st_q.push_back(v);
    -> st_ev;
  endtask
  task automatic wait_susp();
    // frame already spent 4 cycles after chip select rose
    repeat (SUSPEND_LATENCY_CYC - 4) @(negedge clk_sys_i);
  endtask
  task automatic wait_idle(input int lim);
    for (int n = 0; device_idle_flag_o !== 1'b1; n++) begin
      if (n > lim) begin
        chk(16'h0000, 16'h0001, "idle never came");
        results();
      end
      @(negedge clk_sys_i);
    end
  endtask

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(st_ev) begin : st_mon
    logic [4:0] v;
    v = st_q.pop_front();
    chk(16'({write_enable_latch_o, erase_program_error_flag_o, program_suspended_flag_o,
      erase_suspended_flag_o, device_idle_flag_o}), 16'(v), "status flags");
    chk(16'({program_hold_o, erase_hold_o}), 16'(v[2:1]), "engine hold");
  end
  always @(rd_ev) begin
    chk(16'({read_undef_o, read_data_o}), 16'(rd_q.pop_front()), "read data");
  end
  always @(negedge clk_sys_i) begin
    if (op_start_o === 1'b1) begin
      if (kind_q.size() == 0) chk(16'h0001, 16'h0000, "unexpected start");
      else begin
        chk(16'(op_kind_o), 16'(kind_q[0][33:32]), "operation kind");
        chk(op_addr_o, kind_q[0][31:0], "operation address");
        kind_q.delete(0);
      end
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 2; i++) begin
      op = i ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A;
      do_reset();
      frame('{op}, 0);
      expect_st(5'b00001);
      frame('{OP_WRITE_ENABLE}, 0);
      kind_q.push_back({OPK_CHIP_ERASE, 32'h00000000});
      frame('{op, rnd()}, 0);
      expect_st(5'b00000);
      frame('{OP_SUSPEND}, 0);
      wait_susp();
      expect_st(5'b00000);
      op_fail_i = 1'b1;
      @(negedge clk_sys_i);
      op_fail_i = 1'b0;
      expect_st(5'b01000);
      wait_idle(1000);
      expect_st(5'b01001);
    end
    do_reset();
    for (int i = 0; i < 2; i++) begin
      frame('{OP_WRITE_ENABLE}, 0);
      expect_st(5'b10001);
      any_sector_protected_i = i[0];
      frame('{OP_CHIP_ERASE_A}, 5 - 5 * i);
      expect_st(5'b00001);
    end
    any_sector_protected_i = 1'b0;
    frame('{OP_SUSPEND}, 0);
    wait_susp();
    expect_st(5'b00001);
    do_reset();
    frame('{OP_WRITE_ENABLE}, 0);
    kind_q.push_back({OPK_BLOCK_ERASE, 32'h000C0000});
    frame('{OP_BLOCK_ERASE_4K, 8'h00, 8'h0C, 8'h00, 8'h00}, 0);
    frame('{OP_SUSPEND}, 3);
    wait_susp();
    expect_st(5'b00000);
    frame('{OP_SUSPEND, rnd()}, 0);
    wait_susp();
    expect_st(5'b00011);
    read_active_i = 1'b1;
    for (int i = 0; i < 2; i++) begin
      read_addr_i = {9'h000, i[0] ? 5'h05 : 5'h03, 18'(rnd())};
      array_data_i = rnd();
      repeat (2) @(negedge clk_sys_i);
      rd_q.push_back(i[0] ? {1'b0, array_data_i} : {1'b1, UNDEF_READ_BYTE});
      -> rd_ev;
    end
    read_active_i = 1'b0;
    frame('{OP_WRITE_ENABLE}, 0);
    frame('{OP_CHIP_ERASE_A}, 0);
    expect_st(5'b10011);
    frame('{OP_PAGE_PROGRAM, 8'h00, 8'h0C, 8'h01, 8'h00, rnd()}, 0);
    expect_st(5'b00011);
    frame('{OP_WRITE_ENABLE}, 0);
    kind_q.push_back({OPK_PROGRAM, 32'h00140000});
    frame('{OP_PAGE_PROGRAM, 8'h00, 8'h14, 8'h00, 8'h00, rnd()}, 0);
    expect_st(5'b00010);
    chk(target_addr_o, 32'h00140000, "captured address");
    frame('{OP_SUSPEND}, 0);
    wait_susp();
    expect_st(5'b00111);
    frame('{OP_WRITE_ENABLE}, 0);
    frame('{OP_PAGE_PROGRAM, 8'h00, 8'h18, 8'h00, 8'h00, rnd()}, 0);
    frame('{OP_BLOCK_ERASE_64K, 8'h00, 8'h18, 8'h00, 8'h00}, 0);
    expect_st(5'b10111);
    for (int i = 1; i < 3; i++) begin
      do_reset();
      {auto_ultra_deep_powerdown_bit_i, auto_deep_powerdown_bit_i} = 2'(i);
      frame('{OP_WRITE_ENABLE}, 0);
      kind_q.push_back({OPK_BLOCK_ERASE, 32'h00040000});
      frame('{OP_BLOCK_ERASE_32K, 8'h00, 8'h04, 8'h00, 8'h00}, 0);
      frame('{OP_SUSPEND}, 0);
      wait_susp();
      expect_st(5'b00000);
    end
    chk(16'(kind_q.size()), 16'h0000, "missing start");
    results();
  end
endmodule // tb_top
